/* rtl/dsq_pkg.sv */
// Package for the dual-engine pair sequencer: constants, register map, states.
// Assumes a single 100 MHz clock; one converter clock period equals one cycle.
package dsq_pkg;
  localparam int unsigned NUM_PAIRS      = 13;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // Sampling window in converter periods
  localparam int unsigned SAMPLE_TICKS   = 2;
  // Early interrupt point after conversion start
  localparam int unsigned EARLY_TICKS    = 7;
  // Full conversion length in converter periods
  localparam int unsigned CONV_TICKS     = 14;
  // Pairs with a dedicated even sample-and-hold
  localparam int unsigned DEDICATED_PAIRS = 4;
  localparam logic [3:0] OFFSET_STEP     = 4'h4;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_BASE       = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
  localparam logic [7:0] ADDR_ROUTE      = 8'h14;
  localparam logic [7:0] ADDR_PAIR_CTRL0 = 8'h20;
  // Control register field positions
  localparam int unsigned CTRL_EARLY_BIT = 7;
  localparam int unsigned CTRL_SEQ_BIT   = 5;
  localparam int unsigned CTRL_FREE_BIT  = 4;
  localparam int unsigned CTRL_ORDER_BIT = 6;
  localparam int unsigned ROUTE_BIT      = 15;
  localparam logic [15:0] CONTROL_RESET  = 16'h0003;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  typedef enum logic [2:0] {DSQ_IDLE, DSQ_SYNC, DSQ_SAMPLE, DSQ_CONVERT} dsq_state_t;
endpackage

/* rtl/dsq_prio.sv */
// Fixed priority picker: lowest index wins.
// Pure combinational; used for arbitration and for the handler offset.
`timescale 1ns/1ps
module dsq_prio import dsq_pkg::*; #(
  parameter int unsigned WIDTH = 13
) (
  input  wire logic [WIDTH-1:0] req,
  output logic                  any,
  output logic [3:0]            idx
);
  // Scan downward so the lowest set index is kept last
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

/* rtl/dsq_sync.sv */
// Two-flop level synchroniser for request lines.
// Assumes the input is a level held until acknowledged.
`timescale 1ns/1ps
module dsq_sync import dsq_pkg::*; #(
  parameter int unsigned WIDTH = 13
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // First stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* rtl/dsq_top.sv */
// Pair conversion sequencer with individual and shared interrupts.
// Assumes one 100 MHz clock, requests as levels from the processor domain.
// Register port never waits; read data stand for one cycle only.
// Functional notes
// - Sequential-sampling and reverse-order selects are ignored entirely.
// - Dedicated pair, free-running clear: synchronous sampling, parallel conversion.
// - Dedicated pair, free-running set: even input sampled only while the sequencer is idle, parallel conversion.
// - Shared-hold pairs always sample synchronously whatever the selects hold.
// - Requests are synchronised into the converter domain before sampling.
// - Both inputs sampled together for two converter periods; for a free-running dedicated pair only the odd input.
// - Even and odd engines convert concurrently.
// - Early select set: interrupt seven periods after conversion start.
// - Early select clear: interrupt after conversion completes.
// - Each pair has its own interrupt output.
// - Route bit 15 of pair control sends the pair to the shared interrupt.
// - Base register read returns base plus offset of the causing pair.
// - Offset is four times the pair number, 0 to 48.
// - A pair interrupt also sets that pair's result-ready bit.
// - Simultaneous requests served by priority, pair zero first.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module dsq_top import dsq_pkg::*; #(
  parameter int unsigned PAIRS = NUM_PAIRS
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [31:0]      rdata,
  input  wire logic [PAIRS-1:0] pair_request,
  output logic      [PAIRS-1:0] pair_conversion_flag,
  output logic                  shared_conversion_flag,
  output logic                  irq,
  output logic                  even_sample,
  output logic                  odd_sample,
  output logic                  even_convert,
  output logic                  odd_convert,
  output logic      [3:0]       active_pair
);
  logic [15:0]      control_q;
  logic [15:0]      base_q;
  logic [PAIRS-1:0] route_q;
  logic [PAIRS-1:0] pending_q;
  logic [PAIRS-1:0] converter_status_q;
  logic [2:0]       irq_status_q;
  logic [2:0]       irq_mask_q;
  logic [PAIRS-1:0] req_sync;
  logic [PAIRS-1:0] req_prev_q;
  dsq_state_t       state_q;
  logic [3:0]       cnt_q;
  logic [3:0]       cur_q;
  logic             early_done_q;
  logic             any_pending;
  logic [3:0]       next_pair;
  logic             any_shared;
  logic [3:0]       shared_pair;

  // One-hot mask of a pair; used for arbitration clear and event decode
  function automatic logic [PAIRS-1:0] pair_bit(input logic [3:0] idx);
    pair_bit = PAIRS'(1) << idx;
  endfunction

  // Aligned, mapped pair control word; misaligned or spare offsets read as zero
  function automatic logic pair_slot(input logic [7:0] a);
    logic [7:0] rel;
    rel       = a - ADDR_PAIR_CTRL0;
    pair_slot = a >= ADDR_PAIR_CTRL0 && rel[1:0] == 2'b00 && rel[7:2] < PAIRS;
  endfunction

  // Request synchroniser
  // two-flop crossing
  dsq_sync #(.WIDTH(PAIRS)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (pair_request),
    .sync_out (req_sync)
  );

  dsq_prio #(.WIDTH(PAIRS)) u_arb (
    .req (pending_q),
    .any (any_pending),
    .idx (next_pair)
  );

  // lowest ready routed pair names the offset
  dsq_prio #(.WIDTH(PAIRS)) u_shr (
    .req (converter_status_q & route_q),
    .any (any_shared),
    .idx (shared_pair)
  );

  // Decoding
  // Address compares are exact, so unmapped writes fall through harmlessly
  wire        early_sel   = control_q[CTRL_EARLY_BIT];
  wire        free_sel    = control_q[CTRL_FREE_BIT];
  wire        wr_ctrl     = wr_en && addr == ADDR_CONTROL;
  wire        wr_status   = wr_en && addr == ADDR_STATUS;
  wire        wr_base     = wr_en && addr == ADDR_BASE;
  wire        wr_irq_clr  = wr_en && addr == ADDR_IRQ_STATUS;
  wire        wr_mask     = wr_en && addr == ADDR_IRQ_MASK;
  wire        wr_route    = wr_en && addr == ADDR_ROUTE;
  wire [7:0]  pc_rel      = addr - ADDR_PAIR_CTRL0;
  wire        wr_pair     = wr_en && pair_slot(addr);
  wire [3:0]  pc_idx      = pc_rel[5:2];
  wire [PAIRS-1:0] rise   = req_sync & ~req_prev_q;
  // dedicated pair with free-running select clear samples on request
  // dedicated even hold already tracks; request ends the sample at once
  // shared-hold pairs ignore the free-running select
  wire        cur_free    = free_sel && cur_q < DEDICATED_PAIRS;
  // early point counted from conversion start
  // otherwise at full completion
  // Only one event per pair visit, early or late, never both
  wire        conv_evt    = state_q == DSQ_CONVERT &&
                            (early_sel ? (cnt_q == 4'(EARLY_TICKS - 1) && !early_done_q)
                                       : cnt_q == 4'(CONV_TICKS - 1));
  wire [PAIRS-1:0] evt_vec = conv_evt ? pair_bit(cur_q) : '0;
  // base plus offset; offset is four times pair number
  wire [15:0] base_read   = base_q + (any_shared ? 16'(shared_pair) * 16'(OFFSET_STEP) : 16'h0000);
  // Shared event comes from the routed pulse itself; ready bits lag by a cycle
  wire [2:0]  irq_events  = {|(evt_vec & route_q), |evt_vec, conv_evt && early_sel};

  // Configuration registers
  // sequential and order bits are stored but steer nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_q  <= CONTROL_RESET;
      base_q     <= 16'h0000;
      irq_mask_q <= 3'h0;
      route_q    <= '0;
    end else begin
      if (wr_ctrl)  control_q  <= wdata[15:0];
      // Bit 0 is not stored, which keeps every handler address even
      if (wr_base)  base_q     <= {wdata[15:1], 1'b0};
      if (wr_mask)  irq_mask_q <= wdata[2:0];
      if (wr_route) route_q    <= wdata[PAIRS-1:0];
      // route bit lives in bit 15 of the pair control word
      if (wr_pair)  route_q[pc_idx] <= wdata[ROUTE_BIT];
    end
  end

  // Pending latches rising synchronised requests; cleared when served
  // A request rising while its own pair is picked is kept: set wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_q  <= '0;
      req_prev_q <= '0;
    end else begin
      req_prev_q <= req_sync;
      pending_q  <= (pending_q & ~((state_q == DSQ_IDLE && any_pending) ? pair_bit(next_pair) : '0)) | rise;
    end
  end

  // Sequencer: idle, sync settle, sample, convert
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= DSQ_IDLE;
      cnt_q        <= 4'h0;
      cur_q        <= 4'h0;
      early_done_q <= 1'b0;
    end else begin
      case (state_q)
        DSQ_IDLE: begin
          // Counter parked at zero so every phase starts clean
          cnt_q        <= 4'h0;
          early_done_q <= 1'b0;
          if (any_pending) begin
            cur_q   <= next_pair;
            state_q <= DSQ_SYNC;
          end
        end
        // one settle cycle; request to sample strobe spans 5-6 periods
        DSQ_SYNC: begin
          state_q <= DSQ_SAMPLE;
        end
        // two-period sampling window for both inputs, or the odd input alone when cur_free
        DSQ_SAMPLE: begin
          if (cnt_q == 4'(SAMPLE_TICKS - 1)) begin
            cnt_q   <= 4'h0;
            state_q <= DSQ_CONVERT;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        // both engines run together for the full conversion
        DSQ_CONVERT: begin
          // Engines stay busy after an early interrupt until the full count
          if (conv_evt) early_done_q <= 1'b1;
          if (cnt_q == 4'(CONV_TICKS - 1)) begin
            cnt_q   <= 4'h0;
            state_q <= DSQ_IDLE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: state_q <= DSQ_IDLE;
      endcase
    end
  end

  // Status, flags and interrupt; hardware set wins over software clear
  // pair event sets result-ready
  // Shared flag follows the routed ready bits; clearing them drops it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converter_status_q     <= '0;
      irq_status_q           <= 3'h0;
      pair_conversion_flag   <= '0;
      shared_conversion_flag <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      // Write one clears a ready bit; zeros leave it alone
      converter_status_q <= (converter_status_q & ~(wr_status ? wdata[PAIRS-1:0] : '0)) | evt_vec;
      irq_status_q       <= (irq_status_q & ~(wr_irq_clr ? wdata[2:0] : 3'h0)) | irq_events;
      pair_conversion_flag   <= evt_vec;
      // routed pairs with ready data hold the shared line
      shared_conversion_flag <= |((converter_status_q | evt_vec) & route_q);
      irq                    <= |((irq_status_q | irq_events) & irq_mask_q);
    end
  end

  // Analog sequencing strobes and read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      even_sample  <= 1'b0;
      odd_sample   <= 1'b0;
      even_convert <= 1'b0;
      odd_convert  <= 1'b0;
      active_pair  <= 4'h0;
      rdata        <= ZERO_WORD;
    end else begin
      // free-running dedicated hold samples in idle too
      even_sample  <= state_q == DSQ_SAMPLE ? !cur_free : (state_q == DSQ_IDLE && free_sel);
      odd_sample   <= state_q == DSQ_SAMPLE;
      // Both engines follow one state, so they cannot drift apart
      even_convert <= state_q == DSQ_CONVERT;
      odd_convert  <= state_q == DSQ_CONVERT;
      active_pair  <= cur_q;
      if (rd_en) begin
        case (addr)
          ADDR_CONTROL:    rdata <= {16'h0000, control_q};
          ADDR_STATUS:     rdata <= 32'(converter_status_q);
          ADDR_BASE:       rdata <= {16'h0000, base_read};
          ADDR_IRQ_STATUS: rdata <= {29'h0, irq_status_q};
          ADDR_IRQ_MASK:   rdata <= {29'h0, irq_mask_q};
          ADDR_ROUTE:      rdata <= 32'(route_q);
          default:         rdata <= pair_slot(addr) ? {16'h0000, route_q[pc_idx], 15'h0000} : ZERO_WORD;
        endcase
      end else begin
        rdata <= ZERO_WORD;
      end
    end
  end

  // Assertions
  a_early_point: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_CONVERT && early_sel && cnt_q == 4'h6 && !early_done_q) |=> pair_conversion_flag[cur_q])
    else $error("early interrupt missed");
  a_late_point: assert property (@(posedge clk) disable iff (!resetn)
    (|evt_vec && !early_sel) |-> cnt_q == 4'hD)
    else $error("late interrupt at wrong time");
  a_sample_two: assert property (@(posedge clk) disable iff (!resetn)
    $rose(odd_sample) |-> odd_sample[*2] ##1 !odd_sample)
    else $error("sample window not two periods");
  a_parallel_conv: assert property (@(posedge clk) disable iff (!resetn)
    even_convert == odd_convert)
    else $error("engines not concurrent");
  a_ready_set: assert property (@(posedge clk) disable iff (!resetn)
    |evt_vec |=> (converter_status_q & $past(evt_vec)) == $past(evt_vec))
    else $error("ready bit not set");
  a_base_offset: assert property (@(posedge clk) disable iff (!resetn)
    (rd_en && addr == ADDR_BASE && any_shared) |=> rdata[15:0] == $past(base_q) + 16'({$past(shared_pair), 2'b00}))
    else $error("base offset wrong");
  a_prio_pick: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_IDLE && pending_q[0]) |=> cur_q == 4'h0)
    else $error("priority not honoured");
  a_shared_route: assert property (@(posedge clk) disable iff (!resetn)
    |(evt_vec & route_q) |=> shared_conversion_flag)
    else $error("shared flag missed");
  c_early_run: cover property (@(posedge clk) disable iff (!resetn) conv_evt && early_sel);
  c_late_run: cover property (@(posedge clk) disable iff (!resetn) conv_evt && !early_sel);
  c_shared_hit: cover property (@(posedge clk) disable iff (!resetn) shared_conversion_flag);
  c_free_sample: cover property (@(posedge clk) disable iff (!resetn) state_q == DSQ_SAMPLE && cur_free);
  c_queued_pairs: cover property (@(posedge clk) disable iff (!resetn) state_q == DSQ_IDLE && $countones(pending_q) > 1);

  // Sequencing phases
  a_sync_settle: assert property (@(posedge clk) disable iff (!resetn)
    state_q == DSQ_SYNC |=> state_q == DSQ_SAMPLE && cnt_q == 4'h0)
    else $error("sync settle not one cycle");
  a_conv_length: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_CONVERT && cnt_q == 4'hD) |=> state_q == DSQ_IDLE)
    else $error("conversion length wrong");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    state_q == DSQ_IDLE |=> !even_convert && !odd_sample)
    else $error("engines busy while idle");
  a_early_once: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_CONVERT && early_done_q && early_sel) |-> !conv_evt)
    else $error("second early interrupt");

  // Sampling modes
  a_even_free: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_SAMPLE && cur_free) |=> !even_sample)
    else $error("free-running even hold resampled");
  a_even_sync: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_SAMPLE && !cur_free) |=> even_sample)
    else $error("even input not sampled");
  a_shared_hold: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_SAMPLE && cur_q >= 4'(DEDICATED_PAIRS)) |=> even_sample == odd_sample)
    else $error("shared hold pair not synchronous");

  // Interrupts and status
  a_single_flag: assert property (@(posedge clk) disable iff (!resetn)
    $onehot0(pair_conversion_flag))
    else $error("several pair flags at once");
  a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    |(irq_status_q & irq_mask_q) |=> irq)
    else $error("interrupt output low");
  a_shared_event: assert property (@(posedge clk) disable iff (!resetn)
    |(evt_vec & route_q) |=> irq_status_q[2])
    else $error("shared event not latched");
  a_shared_drop: assert property (@(posedge clk) disable iff (!resetn)
    !(|(converter_status_q & route_q)) && !(|evt_vec) |=> !shared_conversion_flag)
    else $error("shared flag stuck");
  a_pair_ready: assert property (@(posedge clk) disable iff (!resetn)
    |pair_conversion_flag |-> (converter_status_q & pair_conversion_flag) == pair_conversion_flag)
    else $error("flag without ready bit");

  // Arbitration and handler offset
  a_prio_second: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == DSQ_IDLE && pending_q[1] && !pending_q[0]) |=> cur_q == 4'h1)
    else $error("pair one skipped");
  a_offset_top: assert property (@(posedge clk) disable iff (!resetn)
    (rd_en && addr == ADDR_BASE && converter_status_q[0] && route_q[0]) |=> rdata[15:0] == $past(base_q))
    else $error("pair zero offset wrong");
  a_base_plain: assert property (@(posedge clk) disable iff (!resetn)
    (rd_en && addr == ADDR_BASE && !any_shared) |=> rdata[15:0] == $past(base_q))
    else $error("base read wrong");
endmodule

/* testbench/dsq_top_tb_top.sv */
// Self-checking bench for the pair sequencer: register port, requests, interrupts.
// Assumes one 100 MHz clock and the register map of the design package.
`timescale 1ns/1ps
module dsq_top_tb_top import dsq_pkg::*;;
  logic        clk, resetn, wr_en, rd_en, shared_conversion_flag, irq;
  logic        even_sample, odd_sample, even_convert, odd_convert;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [12:0] pair_request, pair_conversion_flag, raise, drop;
  logic [3:0]  active_pair;
  int          mismatches, tests_run, cyc;

  dsq_trig_model dsq_trig_model_inst (.clk(clk), .resetn(resetn), .raise(raise), .drop(drop),
    .pair_request(pair_request));
  dsq_top dsq_top_inst (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .pair_request(pair_request),
    .pair_conversion_flag(pair_conversion_flag), .shared_conversion_flag(shared_conversion_flag),
    .irq(irq), .even_sample(even_sample), .odd_sample(odd_sample), .even_convert(even_convert),
    .odd_convert(odd_convert), .active_pair(active_pair));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the scenarios need
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        mismatches++;
        wrap_up();
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // Raise pairs in m, wait for the flag of pair p; measure latency, window, convert cycles
  task automatic run(input logic [12:0] m, input int p, input bit ded, output int lat, output int win,
                     output int cv, output logic [3:0] first);
    int  n;
    bit  done;
    lat = 0;
    win = 0;
    cv = 0;
    done = 0;
    first = 4'hF;
    @(posedge clk);
    raise <= m;
    @(posedge clk);
    raise <= 13'h0000;
    for (n = 1; n < 200 && !done; n++) begin
      #1;
      if (odd_sample === 1'b1 && win == 0) begin
        lat = n;
        first = active_pair;
      end
      if (odd_sample === 1'b1) win++;
      if (even_convert === 1'b1) cv++;
      if (odd_sample === 1'b1) chk({31'h0, even_sample}, {31'h0, !ded}); // even hold
      chk({31'h0, even_convert}, {31'h0, odd_convert}); // engines run together
      if (pair_conversion_flag[p] === 1'b1) done = 1;
      @(posedge clk);
    end
    chk({31'h0, done}, 32'h1); // pair flag arrives
    drop <= m;
    @(posedge clk);
    drop <= 13'h0000;
  endtask

  // Reset values, unmapped read
  task automatic t_reset();
    rd(ADDR_CONTROL, r);
    chk(r, {16'h0, CONTROL_RESET});
    rd(ADDR_STATUS, r);
    chk(r, ZERO_WORD);
    rd(8'hFC, r);
    chk(r, ZERO_WORD);
  endtask

  // Each mode setting on a single pair; ignored selects must not alter timing
  task automatic t_modes();
    logic [7:0] ctl [5] = '{8'h80, 8'h00, 8'h60, 8'h10, 8'hF0};
    int         pr  [5] = '{2, 2, 6, 0, 9};
    int         lat, win, cv, i;
    logic [3:0] f;
    for (i = 0; i < 5; i++) begin
      wr(ADDR_CONTROL, {24'h0, ctl[i]});
      run(13'h0001 << pr[i], pr[i], ctl[i][4] && pr[i] < DEDICATED_PAIRS, lat, win, cv, f);
      chk({31'h0, lat >= 2 && lat <= 7}, 32'h1); // sync delay
      chk(win, SAMPLE_TICKS); // window
      chk({31'h0, cv < CONV_TICKS - 2}, {31'h0, ctl[i][7]}); // flag point
      rd(ADDR_STATUS, r);
      chk(r, 32'h1 << pr[i]); // ready bit
      wr(ADDR_IRQ_STATUS, 32'h7);
      wr(ADDR_STATUS, 32'h1FFF);
    end
  endtask

  // Three routed pairs at once: order, shared flag and handler offsets
  task automatic t_shared();
    int         lat, win, cv;
    logic [3:0] f;
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_BASE, 32'h0100);
    wr(ADDR_PAIR_CTRL0 + 8'h04, 32'h8000);
    wr(ADDR_PAIR_CTRL0 + 8'h14, 32'h8000);
    wr(ADDR_PAIR_CTRL0 + 8'h30, 32'h8000);
    run(13'h1022, 12, 1'b0, lat, win, cv, f);
    chk({28'h0, f}, 32'h1); // pair one first
    rd(ADDR_STATUS, r);
    chk(r, 32'h1022); // all ready
    chk({31'h0, shared_conversion_flag}, 32'h1); // shared raised
    rd(ADDR_BASE, r);
    chk(r, 32'h0104); // lowest ready
    rd(ADDR_IRQ_STATUS, r);
    chk(r, 32'h6); // shared and pair events
    wr(ADDR_IRQ_STATUS, 32'h7); // interrupt status cleared first
    wr(ADDR_STATUS, 32'h0002); // then the ready bit
    rd(ADDR_BASE, r);
    chk(r, 32'h0114); // next ready
    wr(ADDR_STATUS, 32'h0020);
    rd(ADDR_BASE, r);
    chk(r, 32'h0130); // top offset
    wr(ADDR_STATUS, 32'h1000);
    @(posedge clk);
    #1 chk({31'h0, shared_conversion_flag}, 32'h0); // shared drops
  endtask

  // Interrupt output follows mask, cleared by writing ones
  task automatic t_irq();
    int         lat, win, cv;
    logic [3:0] f;
    logic       a;
    wr(ADDR_IRQ_MASK, 32'h7);
    run(13'h0008, 3, 1'b0, lat, win, cv, f);
    rd(ADDR_IRQ_STATUS, r);
    chk(r, 32'h2); // pair event latched
    @(posedge clk);
    #1 a = irq;
    wr(ADDR_IRQ_MASK, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, a ^ irq}, 32'h1); // mask gates output
    wr(ADDR_IRQ_STATUS, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h7);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0); // cleared
  endtask

  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    raise = 13'h0000;
    drop = 13'h0000;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_modes();
    t_shared();
    t_irq();
    wrap_up();
  end
endmodule

/* testbench/dsq_trig_model.sv */
// Trigger source model: one request level per pair, raised and dropped by the bench.
// Assumes raise and drop pulses arrive one clock long, off the sampling edge.
`timescale 1ns/1ps
module dsq_trig_model import dsq_pkg::*; (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [12:0] raise,
  input  wire logic [12:0] drop,
  output logic      [12:0] pair_request
);
  // Levels stay up until dropped, so the sequencer sees a clean rising edge.
  // Several bits may rise on one edge to exercise arbitration.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pair_request <= 13'h0000;
    end else begin
      pair_request <= (pair_request | raise) & ~drop;
    end
  end
endmodule
